// *** logic/cie_params.svh ***
`ifndef CIE_PARAMS_SVH
`define CIE_PARAMS_SVH

// register byte offsets
`define CIE_OFF_INSTR   8'h00
`define CIE_OFF_ACC     8'h04
`define CIE_OFF_STATUS  8'h08
`define CIE_OFF_PC      8'h0C
`define CIE_OFF_STACK   8'h10
`define CIE_OFF_WDOG    8'h14
`define CIE_OFF_FADDR   8'h18
`define CIE_OFF_FDATA   8'h1C
`define CIE_OFF_WAKE    8'h20

// status field positions
`define CIE_ST_C        0
`define CIE_ST_HC       1
`define CIE_ST_Z        2
`define CIE_ST_PDN      3
`define CIE_ST_TO       4
`define CIE_ST_BUSY     8
`define CIE_ST_SLEEP    9

// instruction word fields
`define CIE_OPC_HI      11
`define CIE_OPC_LO      8
`define CIE_DIR_BIT     7

// operation codes
`define CIE_OPC_NOP     4'h0
`define CIE_OPC_RET     4'h1
`define CIE_OPC_SLEEP   4'h2
`define CIE_OPC_SUBL    4'h3
`define CIE_OPC_XORL    4'h4
`define CIE_OPC_SUBF    4'h5
`define CIE_OPC_XORF    4'h6
`define CIE_OPC_SWAP    4'h7

// reset values
`define CIE_RST_TO      1'b1
`define CIE_RST_PDN     1'b1
`define CIE_RST_ACC     8'h00
`define CIE_RST_PC      13'h0000

// bus answers
`define CIE_RESP_OKAY   2'b00
`define CIE_RESP_SLVERR 2'b10

`endif

// *** logic/cie_pkg.sv ***
`default_nettype none
`include "cie_params.svh"

package cie_pkg;
	// execution sequencer, one-hot
	typedef enum logic [3:0] {
		CIE_IDLE  = 4'b0001,
		CIE_EXEC  = 4'b0010,
		CIE_RET2  = 4'b0100,
		CIE_SLEEP = 4'b1000
	} cie_state_t;

	typedef enum logic [3:0] {
		CIE_NOP   = `CIE_OPC_NOP,
		CIE_RET   = `CIE_OPC_RET,
		CIE_SLP   = `CIE_OPC_SLEEP,
		CIE_SUBL  = `CIE_OPC_SUBL,
		CIE_XORL  = `CIE_OPC_XORL,
		CIE_SUBF  = `CIE_OPC_SUBF,
		CIE_XORF  = `CIE_OPC_XORF,
		CIE_SWAP  = `CIE_OPC_SWAP
	} cie_op_t;
endpackage

`default_nettype wire

// *** logic/cie_exec.sv ***
// Notes on behaviour
// RQ1 - a return pops the return stack into the program counter and leaves every flag alone.
// RQ2 - a return keeps the core busy for two instruction cycles instead of one.
// RQ3 - sleep clears the watchdog counter and its prescaler to zero.
// RQ4 - sleep sets the time-out flag, clears the power-down flag and touches no other flag.
// RQ5 - after those updates sleep halts execution and stops the oscillator.
// RQ6 - literal minus accumulator goes to the accumulator and updates carry, half carry and zero.
// RQ7 - register minus accumulator updates carry, half carry and zero and goes to the destination.
// RQ8 - accumulator xor literal goes to the accumulator and updates only zero.
// RQ9 - accumulator xor register goes to the destination and updates only zero.
// RQ10 - nibble exchange swaps the two halves of the register and changes no flag.
// RQ11 - register forms use a 7-bit address and a direction bit, 0 to accumulator, 1 to register.
// RQ12 - zero marks a zero result and carry or half carry read 1 when no borrow occurred.
`timescale 1ns/1ps
`default_nettype none
`include "cie_params.svh"

module cie_exec #(
	parameter int STACK_DEPTH = 8,
	parameter int WDOG_PRE_W  = 8
) (
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire logic [7:0]         s_axi_awaddr,
	input  wire logic [2:0]         s_axi_awprot,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [7:0]         s_axi_araddr,
	input  wire logic [2:0]         s_axi_arprot,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	output logic                    sleep_mode,
	output logic                    osc_run
);
	import cie_pkg::*;

	localparam int SP_W = $clog2(STACK_DEPTH);

	// ----------------------------------------
	// parameter checks
	// ----------------------------------------
	if (STACK_DEPTH < 2 || STACK_DEPTH > 16 || (1 << SP_W) != STACK_DEPTH) begin : g_chk_stack
		$error("STACK_DEPTH must be a power of two from 2 to 16");
	end
	if (WDOG_PRE_W < 1 || WDOG_PRE_W > 8) begin : g_chk_pre
		$error("WDOG_PRE_W must be 1 to 8");
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// returns {carry, half carry, result}; carry means no borrow
	function automatic logic [9:0] sub8(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] full;
		logic [4:0] low;
		full = {1'b0, a} + {1'b0, ~b} + 9'h001;
		low  = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
		return {full[8], low[4], full[7:0]};
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	cie_state_t        st_q;
	logic [11:0]       instr_q;
	logic [7:0]        acc_q;
	logic              c_q, hc_q, z_q, to_q, pdn_q;
	logic [12:0]       pc_q;
	logic [12:0]       stack_mem [STACK_DEPTH];
	logic [SP_W-1:0]   sp_q;
	logic [7:0]        fmem [128];
	logic [6:0]        faddr_q;
	logic [7:0]        wdog_q;
	logic [WDOG_PRE_W-1:0] pre_q;
	logic              aw_full_q, w_full_q;
	logic [7:0]        awaddr_q;
	logic [31:0]       wdata_q;
	logic [3:0]        wstrb_q;

	// ----------------------------------------
	// decode and datapath
	// ----------------------------------------
	cie_op_t     ex_op;
	logic        ex_dir;
	logic [6:0]  ex_f;
	logic [7:0]  ex_k, fval, res;
	logic [9:0]  subl_r, subf_r;
	logic        exec, ex_sub, ex_xor, wr_acc, wr_f;
	logic [12:0] stack_top_entry;

	assign ex_op  = cie_op_t'(instr_q[`CIE_OPC_HI:`CIE_OPC_LO]);
	assign ex_dir = instr_q[`CIE_DIR_BIT];           // RQ11
	assign ex_f   = instr_q[6:0];                    // RQ11
	assign ex_k   = instr_q[7:0];
	assign fval   = fmem[ex_f];
	assign exec   = (st_q == CIE_EXEC);
	assign subl_r = sub8(ex_k, acc_q);               // RQ6
	assign subf_r = sub8(fval, acc_q);               // RQ7
	assign ex_sub = (ex_op == CIE_SUBL) || (ex_op == CIE_SUBF);
	assign ex_xor = (ex_op == CIE_XORL) || (ex_op == CIE_XORF);
	assign stack_top_entry = stack_mem[sp_q - SP_W'(1)];

	// result select; unknown codes behave as no-operation
	always_comb begin
		res    = acc_q;
		wr_acc = 1'b0;
		wr_f   = 1'b0;
		case (ex_op)
			CIE_SUBL: begin
				res    = subl_r[7:0];                    // RQ6
				wr_acc = exec;
			end
			CIE_XORL: begin
				res    = acc_q ^ ex_k;                   // RQ8
				wr_acc = exec;
			end
			CIE_SUBF, CIE_XORF, CIE_SWAP: begin
				if (ex_op == CIE_SUBF) begin
					res = subf_r[7:0];                   // RQ7
				end else if (ex_op == CIE_XORF) begin
					res = acc_q ^ fval;                  // RQ9
				end else begin
					res = {fval[3:0], fval[7:4]};        // RQ10
				end
				wr_acc = exec && !ex_dir;                // RQ11
				wr_f   = exec && ex_dir;                 // RQ11
			end
			default: begin
				res = acc_q;
			end
		endcase
	end

	// ----------------------------------------
	// bus write decode
	// ----------------------------------------
	logic        wr_do, wr_ok, busy;
	logic [7:0]  wa;
	logic [31:0] wv;

	assign busy  = (st_q == CIE_EXEC) || (st_q == CIE_RET2);
	assign wr_do = aw_full_q && w_full_q && !s_axi_bvalid;
	assign wa    = {awaddr_q[7:2], 2'b00};
	assign wv    = merge(32'h0000_0000, wdata_q, wstrb_q);

	// busy refuses every write so software never races the datapath
	always_comb begin
		wr_ok = 1'b0;
		if (wr_do && !busy) begin
			case (wa)
				`CIE_OFF_INSTR:  wr_ok = (st_q == CIE_IDLE);
				`CIE_OFF_ACC, `CIE_OFF_STATUS, `CIE_OFF_PC, `CIE_OFF_STACK,
				`CIE_OFF_FADDR, `CIE_OFF_FDATA, `CIE_OFF_WAKE: wr_ok = 1'b1;
				default:         wr_ok = 1'b0;
			endcase
		end
	end

	// ----------------------------------------
	// write channels
	// ----------------------------------------
	// address and data are caught in either order, released on the response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			aw_full_q     <= 1'b0;
			w_full_q      <= 1'b0;
			awaddr_q      <= 8'h00;
			wdata_q       <= 32'h0000_0000;
			wstrb_q       <= 4'h0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `CIE_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_q     <= 1'b1;
				awaddr_q      <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_q     <= 1'b1;
				wdata_q      <= s_axi_wdata;
				wstrb_q      <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_do) begin
				aw_full_q    <= 1'b0;
				w_full_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? `CIE_RESP_OKAY : `CIE_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// read channel
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `CIE_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= `CIE_RESP_OKAY;
			case ({s_axi_araddr[7:2], 2'b00})
				`CIE_OFF_INSTR:  s_axi_rdata <= {20'h00000, instr_q};
				`CIE_OFF_ACC:    s_axi_rdata <= {24'h000000, acc_q};
				`CIE_OFF_STATUS: s_axi_rdata <= {22'h000000, sleep_mode, busy, 3'b000,
						to_q, pdn_q, z_q, hc_q, c_q};
				`CIE_OFF_PC:     s_axi_rdata <= {19'h00000, pc_q};
				`CIE_OFF_STACK:  s_axi_rdata <= {19'h00000, stack_top_entry};
				`CIE_OFF_WDOG:   s_axi_rdata <= {16'h0000, 8'(pre_q), wdog_q};
				`CIE_OFF_FADDR:  s_axi_rdata <= {25'h0000000, faddr_q};
				`CIE_OFF_FDATA:  s_axi_rdata <= {24'h000000, fmem[faddr_q]};
				`CIE_OFF_WAKE:   s_axi_rdata <= 32'h0000_0000;
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `CIE_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q       <= CIE_IDLE;
			instr_q    <= 12'h000;
			sleep_mode <= 1'b0;
			osc_run    <= 1'b1;
		end else begin
			unique case (st_q)
				CIE_IDLE: begin
					if (wr_ok && wa == `CIE_OFF_INSTR) begin
						instr_q <= 12'(merge(32'h0000_0000, wdata_q, wstrb_q));
						st_q    <= CIE_EXEC;
					end
				end
				CIE_EXEC: begin
					if (ex_op == CIE_RET) begin
						st_q <= CIE_RET2;                // RQ2
					end else if (ex_op == CIE_SLP) begin
						st_q       <= CIE_SLEEP;         // RQ5
						sleep_mode <= 1'b1;              // RQ5
						osc_run    <= 1'b0;              // RQ5
					end else begin
						st_q <= CIE_IDLE;
					end
				end
				CIE_RET2: st_q <= CIE_IDLE;              // RQ2
				CIE_SLEEP: begin
					// wake sources live outside; software stands in for them here
					if (wr_ok && wa == `CIE_OFF_WAKE) begin
						st_q       <= CIE_IDLE;
						sleep_mode <= 1'b0;
						osc_run    <= 1'b1;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// accumulator and flags
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_q <= `CIE_RST_ACC;
		end else if (wr_acc) begin
			acc_q <= res;                                // RQ6 RQ8 RQ11
		end else if (wr_ok && wa == `CIE_OFF_ACC) begin
			acc_q <= wv[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			c_q   <= 1'b0;
			hc_q  <= 1'b0;
			z_q   <= 1'b0;
			to_q  <= `CIE_RST_TO;
			pdn_q <= `CIE_RST_PDN;
		end else if (exec) begin
			if (ex_sub) begin
				c_q  <= (ex_op == CIE_SUBL) ? subl_r[9] : subf_r[9];  // RQ12
				hc_q <= (ex_op == CIE_SUBL) ? subl_r[8] : subf_r[8];  // RQ12
			end
			if (ex_sub || ex_xor) begin
				z_q <= (res == 8'h00);                   // RQ12 RQ8 RQ9
			end
			if (ex_op == CIE_SLP) begin
				to_q  <= 1'b1;                           // RQ4
				pdn_q <= 1'b0;                           // RQ4
			end
		end else if (wr_ok && wa == `CIE_OFF_STATUS) begin
			c_q  <= wv[`CIE_ST_C];
			hc_q <= wv[`CIE_ST_HC];
			z_q  <= wv[`CIE_ST_Z];
		end
	end

	// ----------------------------------------
	// program counter and return stack
	// ----------------------------------------
	// the stack is circular: overflow overwrites the oldest entry silently
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pc_q <= `CIE_RST_PC;
			sp_q <= '0;
		end else if (exec && ex_op == CIE_RET) begin
			pc_q <= stack_top_entry;                     // RQ1
			sp_q <= sp_q - SP_W'(1);                     // RQ1
		end else if (wr_ok && wa == `CIE_OFF_PC) begin
			pc_q <= wv[12:0];
		end else if (wr_ok && wa == `CIE_OFF_STACK) begin
			sp_q <= sp_q + SP_W'(1);
		end
	end

	always_ff @(posedge aclk) begin
		if (wr_ok && wa == `CIE_OFF_STACK) begin
			stack_mem[sp_q] <= wv[12:0];
		end
	end

	// ----------------------------------------
	// file registers
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (wr_f) begin
			fmem[ex_f] <= res;                           // RQ7 RQ9 RQ10 RQ11
		end else if (wr_ok && wa == `CIE_OFF_FDATA) begin
			fmem[faddr_q] <= wv[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			faddr_q <= 7'h00;
		end else if (wr_ok && wa == `CIE_OFF_FADDR) begin
			faddr_q <= wv[6:0];
		end
	end

	// ----------------------------------------
	// watchdog
	// ----------------------------------------
	// counts only while the oscillator runs, so it stands still in sleep
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wdog_q <= 8'h00;
			pre_q  <= '0;
		end else if (exec && ex_op == CIE_SLP) begin
			wdog_q <= 8'h00;                             // RQ3
			pre_q  <= '0;                                // RQ3
		end else if (osc_run) begin
			pre_q <= pre_q + WDOG_PRE_W'(1);
			if (&pre_q) begin
				wdog_q <= wdog_q + 8'h01;
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic is_ret, is_slp, is_subl, is_subf, is_xorl, is_xorf, is_swap;
	assign is_ret  = exec && ex_op == CIE_RET;
	assign is_slp  = exec && ex_op == CIE_SLP;
	assign is_subl = exec && ex_op == CIE_SUBL;
	assign is_subf = exec && ex_op == CIE_SUBF;
	assign is_xorl = exec && ex_op == CIE_XORL;
	assign is_xorf = exec && ex_op == CIE_XORF;
	assign is_swap = exec && ex_op == CIE_SWAP;

	a_ret_pc_load: assert property (is_ret |=> pc_q == $past(stack_top_entry) // RQ1
		&& c_q == $past(c_q) && z_q == $past(z_q) && hc_q == $past(hc_q))
		else $error("return did not load pc from stack top cleanly");
	a_ret_two_cycles: assert property (is_ret |=> st_q == CIE_RET2 ##1 st_q == CIE_IDLE) // RQ2
		else $error("return did not take two cycles");
	a_sleep_wdog_clear: assert property (is_slp |=> wdog_q == 8'h00 && pre_q == '0) // RQ3
		else $error("sleep left watchdog uncleared");
	a_sleep_flags: assert property (is_slp |=> to_q && !pdn_q && $stable(c_q) // RQ4
		&& $stable(hc_q) && $stable(z_q))
		else $error("sleep status flags wrong");
	a_sleep_halt: assert property (is_slp |=> !osc_run && sleep_mode // RQ5
		##1 (st_q == CIE_SLEEP || st_q == CIE_IDLE) && $stable(wdog_q))
		else $error("sleep did not halt the core");
	a_lit_sub_result: assert property (is_subl |=> acc_q == 8'($past(ex_k) - $past(acc_q)) // RQ6
		&& c_q == ($past(ex_k) >= $past(acc_q)) && z_q == (acc_q == 8'h00))
		else $error("literal subtract wrong");
	a_reg_sub_dest: assert property (is_subf && !ex_dir |=> // RQ7
		acc_q == 8'($past(fval) - $past(acc_q)) && c_q == ($past(fval) >= $past(acc_q)))
		else $error("register subtract to accumulator wrong");
	a_dest_reg_keeps_acc: assert property ((is_subf || is_xorf || is_swap) && ex_dir // RQ11
		|=> $stable(acc_q))
		else $error("register destination disturbed the accumulator");
	a_xor_lit_flags: assert property (is_xorl |=> acc_q == ($past(acc_q) ^ $past(ex_k)) // RQ8
		&& z_q == (acc_q == 8'h00) && $stable(c_q) && $stable(hc_q))
		else $error("literal xor wrong");
	a_xor_reg_result: assert property (is_xorf && !ex_dir |=> // RQ9
		acc_q == ($past(acc_q) ^ $past(fval)) && $stable(c_q))
		else $error("register xor wrong");
	a_swap_nibbles: assert property (is_swap && !ex_dir |=> acc_q[7:4] == $past(fval[3:0]) // RQ10
		&& acc_q[3:0] == $past(fval[7:4]) && $stable(z_q) && $stable(c_q))
		else $error("nibble exchange wrong");
	a_half_carry: assert property (is_subl |=> // RQ12
		hc_q == ($past(ex_k[3:0]) >= $past(acc_q[3:0])))
		else $error("half carry wrong");

	c_ret: cover property (is_ret ##2 st_q == CIE_IDLE);
	c_sleep_wake: cover property (is_slp ##[1:1000] st_q == CIE_IDLE);
	c_subf_to_reg: cover property (is_subf && ex_dir);
	c_zero_result: cover property (is_xorl ##1 z_q);

endmodule

`default_nettype wire

// *** verif/cie_exec_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cie_params.svh"

module cie_exec_tb;
	// ------------------------------------------------------------
	// bench signals
	// ------------------------------------------------------------
	localparam logic [1:0] OK = `CIE_RESP_OKAY;
	localparam logic [1:0] ER = `CIE_RESP_SLVERR;

	typedef struct {
		string       nm;
		logic [31:0] d;
		logic [1:0]  r;
	} cie_exp_t;

	logic        aclk;
	logic        aresetn;
	logic [7:0]  awaddr, araddr;
	logic [2:0]  awprot, arprot;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [1:0]  bresp, rresp;
	logic        sleep_mode, osc_run;
	cie_exp_t    exp_q[$];
	cie_exp_t    cur;
	int          err_total = 0;
	int          checked   = 0;
	int          seed      = 32'h06ff;
	int          cyc       = 0;
	logic [7:0]  a, k, res, ea, ef;
	logic [6:0]  f;
	logic        dir;
	logic [2:0]  fl, efl;
	logic [3:0]  op;

	cie_exec u_dut (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awaddr  (awaddr),
		.s_axi_awprot  (awprot),
		.s_axi_awvalid (awvalid),
		.s_axi_awready (awready),
		.s_axi_wdata   (wdata),
		.s_axi_wstrb   (wstrb),
		.s_axi_wvalid  (wvalid),
		.s_axi_wready  (wready),
		.s_axi_bresp   (bresp),
		.s_axi_bvalid  (bvalid),
		.s_axi_bready  (bready),
		.s_axi_araddr  (araddr),
		.s_axi_arprot  (arprot),
		.s_axi_arvalid (arvalid),
		.s_axi_arready (arready),
		.s_axi_rdata   (rdata),
		.s_axi_rresp   (rresp),
		.s_axi_rvalid  (rvalid),
		.s_axi_rready  (rready),
		.sleep_mode    (sleep_mode),
		.osc_run       (osc_run)
	);

	// ------------------------------------------------------------
	// clock, hang guard and verdict
	// ------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// the whole run needs a few thousand cycles, so this only trips on a hang
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			stop_test();
		end
	end

	// ------------------------------------------------------------
	// bus master tasks; each notes its expected answer first
	// ------------------------------------------------------------
	task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] r);
		exp_q.push_back('{"bresp", 32'h0, r});
		awaddr  <= ad;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		// readies stay low after a handshake, so a late drop is harmless
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
	endtask

	task automatic rd(input string nm, input logic [7:0] ad, input logic [31:0] d,
			input logic [1:0] r);
		exp_q.push_back('{nm, d, r});
		araddr  <= ad;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
	endtask

	// instruction write, then wait three cycles for the sequencer to settle in idle or sleep
	task automatic run(input logic [11:0] ins);
		wr(`CIE_OFF_INSTR, {20'h0, ins}, OK);
		repeat (3) @(posedge aclk);
	endtask

	// ------------------------------------------------------------
	// answer watcher: oldest note against each bus answer
	// ------------------------------------------------------------
	always @(posedge aclk) begin
		if (aresetn && ((bvalid && bready) || (rvalid && rready))) begin
			if (exp_q.size() == 0) begin
				chk("unexpected answer", 32'h1, 32'h0);
			end else begin
				cur = exp_q.pop_front();
				if (rvalid) begin
					chk(cur.nm, rdata, cur.d);
					chk("rresp", {30'h0, rresp}, {30'h0, cur.r});
				end else begin
					chk(cur.nm, {30'h0, bresp}, {30'h0, cur.r});
				end
			end
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		aresetn = 1'b0;
		awaddr  = 8'h00;
		araddr  = 8'h00;
		awprot  = 3'h0;
		arprot  = 3'h0;
		wdata   = 32'h0;
		wstrb   = 4'hF;
		awvalid = 1'b0;
		wvalid  = 1'b0;
		bready  = 1'b0;
		arvalid = 1'b0;
		rready  = 1'b0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		// reset state and unmapped places
		rd("acc", `CIE_OFF_ACC, 32'h0, OK);
		rd("status", `CIE_OFF_STATUS, 32'h18, OK);
		rd("pc", `CIE_OFF_PC, 32'h0, OK);
		rd("unmapped", 8'h24, 32'h0, ER);
		wr(8'h24, 32'hFF, ER);
		// arithmetic and logic forms with random operands, equal operands every fourth pass
		for (int i = 0; i < 40; i++) begin
			a   = 8'($random(seed));
			k   = 8'($random(seed));
			f   = 7'($random(seed));
			dir = 1'($random(seed));
			fl  = 3'($random(seed));
			if (i % 4 == 0) k = a;
			op = 4'h3 + 4'(i % 5);
			wr(`CIE_OFF_FADDR, {25'h0, f ^ 7'h01}, OK);
			wr(`CIE_OFF_FDATA, {24'h0, ~k}, OK);
			wr(`CIE_OFF_FADDR, {25'h0, f}, OK);
			wr(`CIE_OFF_FDATA, {24'h0, k}, OK);
			wr(`CIE_OFF_ACC, {24'h0, a}, OK);
			wr(`CIE_OFF_STATUS, {29'h0, fl}, OK);
			efl = fl;
			case (op)
				`CIE_OPC_SUBL, `CIE_OPC_SUBF: begin
					res = k - a;
					efl = {res == 8'h00, k[3:0] >= a[3:0], k >= a};
				end
				`CIE_OPC_XORL, `CIE_OPC_XORF: begin
					res    = k ^ a;
					efl[2] = res == 8'h00;
				end
				default: res = {k[3:0], k[7:4]};
			endcase
			ea = a;
			ef = k;
			if (op >= 4'h5 && dir) ef = res;
			else ea = res;
			run({op, (op >= 4'h5) ? {dir, f} : k});
			rd("acc", `CIE_OFF_ACC, {24'h0, ea}, OK);
			rd("file", `CIE_OFF_FDATA, {24'h0, ef}, OK);
			rd("flags", `CIE_OFF_STATUS, {29'h3, efl}, OK);
			wr(`CIE_OFF_FADDR, {25'h0, f ^ 7'h01}, OK);
			rd("neighbour", `CIE_OFF_FDATA, {24'h0, ~k}, OK);
		end
		// return: pop order, no flag change, busy through a second cycle
		wr(`CIE_OFF_ACC, 32'h3C, OK);
		wr(`CIE_OFF_STACK, 32'h0123, OK);
		wr(`CIE_OFF_STACK, 32'h1ABC, OK);
		rd("stack top", `CIE_OFF_STACK, 32'h1ABC, OK);
		wr(`CIE_OFF_STATUS, 32'h5, OK);
		wr(`CIE_OFF_INSTR, {20'h0, `CIE_OPC_RET, 8'h00}, OK);
		rd("busy", `CIE_OFF_STATUS, 32'h11D, OK);
		rd("pc", `CIE_OFF_PC, 32'h1ABC, OK);
		rd("stack top", `CIE_OFF_STACK, 32'h0123, OK);
		rd("status", `CIE_OFF_STATUS, 32'h1D, OK);
		rd("acc", `CIE_OFF_ACC, 32'h3C, OK);
		run({`CIE_OPC_RET, 8'h00});
		rd("pc", `CIE_OFF_PC, 32'h0123, OK);
		// a single-cycle operation frees the bus one cycle earlier
		wr(`CIE_OFF_INSTR, {20'h0, `CIE_OPC_NOP, 8'hFF}, OK);
		rd("not busy", `CIE_OFF_STATUS, 32'h1D, OK);
		wr(`CIE_OFF_ACC, 32'h66, OK);
		rd("acc", `CIE_OFF_ACC, 32'h66, OK);
		// sleep: watchdog cleared and frozen, status bits, halt
		repeat (300) @(posedge aclk);
		run({`CIE_OPC_SLEEP, 8'h00});
		chk("sleep_mode", {31'h0, sleep_mode}, 32'h1);
		chk("osc_run", {31'h0, osc_run}, 32'h0);
		rd("wdog", `CIE_OFF_WDOG, 32'h0, OK);
		repeat (300) @(posedge aclk);
		rd("wdog held", `CIE_OFF_WDOG, 32'h0, OK);
		rd("status", `CIE_OFF_STATUS, 32'h215, OK);
		wr(`CIE_OFF_INSTR, {20'h0, `CIE_OPC_XORL, 8'hFF}, ER);
		rd("acc", `CIE_OFF_ACC, 32'h66, OK);
		wr(`CIE_OFF_WAKE, 32'h1, OK);
		repeat (2) @(posedge aclk);
		chk("sleep_mode", {31'h0, sleep_mode}, 32'h0);
		chk("osc_run", {31'h0, osc_run}, 32'h1);
		rd("status", `CIE_OFF_STATUS, 32'h15, OK);
		stop_test();
	end
endmodule

`default_nettype wire
